//--- hdl/staging_write_path.v
// Functional notes
// (R01) End offset loads start, counts each byte
// (R02) Partial flag set on power loss, short write
// (R03) Master writes from offset 0, eight bytes
// (R04) Status bits 3, 4, 6 read zero
// (R05) Copy-done flag cleared by staging write
// (R06) Nonzero low address bits block commit
// (R07) Readback order: low, high, status, data
// (R08) Master retries write when partial flag set
// (R09) Master reads copy-done with no partial as unrecognised
// (R10) Commit carries low, high, status bytes
// (R11) Speed select: zero standard, one fast
// (R12) Command then low, high address, data
// (R13) Data placed from low address bits, whole bytes
// (R14) Bad address or short row accepted, commit blocked
// (R15) Checksum cleared, fed command, address, data
// (R16) Inverted checksum returned after offset seven
// (R17) Write-locked target loads existing memory
// (R18) AND mode loads data AND memory
// (R19) Data pages and writable register bytes accepted
// (R20) Early end leaves last complete offset
// (R21) 55h locks, AAh AND mode, else open
// (R22) Matching commit sets copy-done, copies row
`timescale 1ns/1ps
`default_nettype none
`include "staging_consts.vh"

// ==========================================================================
// Staging buffer write path with readback and commit
// ==========================================================================
module staging_write_path #(
  parameter ROW_BYTES = 8
) (
  input  wire        clock,             // System clock, 100 MHz
  input  wire        rst,               // Synchronous reset, power loss
  input  wire        speed_fast_req,    // Pulse: switch to fast speed
  input  wire        speed_std_req,     // Pulse: back to standard speed
  output reg         fast_speed_select, // Current link speed
  input  wire        frame_start,       // Pulse: memory command follows
  input  wire        frame_end,         // Pulse: master ended transaction
  input  wire        rx_valid,          // Pulse: one complete byte
  input  wire [7:0]  rx_data,           // Byte from master
  output wire        tx_valid,          // Byte to master present
  input  wire        tx_ready,          // Link takes byte
  output wire [7:0]  tx_data,           // Byte to master
  output reg  [15:0] mem_addr,          // Array address being looked at
  input  wire [7:0]  mem_rdata,         // Array byte at mem_addr
  input  wire [7:0]  page_prot,         // Protection byte of that page
  input  wire [7:0]  copy_prot,         // Copy protection byte
  output reg         copy_start,        // Pulse: commit row at mem_addr
  input  wire [2:0]  scratch_sel,       // Staging byte picked by array
  output reg  [7:0]  scratch_out        // Picked byte, one cycle later
);

  // ========================================================================
  // States
  // ========================================================================
  localparam [3:0] S_IDLE     = 4'h0;
  localparam [3:0] S_CMD      = 4'h1;
  localparam [3:0] S_W_AL     = 4'h2;
  localparam [3:0] S_W_AH     = 4'h3;
  localparam [3:0] S_W_DATA   = 4'h4;
  localparam [3:0] S_W_CRC_LO = 4'h5;
  localparam [3:0] S_W_CRC_HI = 4'h6;
  localparam [3:0] S_R_AL     = 4'h7;
  localparam [3:0] S_R_AH     = 4'h8;
  localparam [3:0] S_R_ST     = 4'h9;
  localparam [3:0] S_R_DATA   = 4'ha;
  localparam [3:0] S_R_CRC_LO = 4'hb;
  localparam [3:0] S_R_CRC_HI = 4'hc;
  localparam [3:0] S_C_PAT    = 4'hd;
  localparam [3:0] S_HOLD     = 4'he;

  // Protection outcome codes
  localparam [1:0] P_OPEN = 2'h0;
  localparam [1:0] P_LOCK = 2'h1;
  localparam [1:0] P_AND  = 2'h2;

  // ========================================================================
  // Storage and control
  // ========================================================================
  reg [3:0]  state;                     // Command sequencer
  reg [7:0]  target_address_low;        // Target address, low byte
  reg [7:0]  target_address_high;       // Target address, high byte
  reg [2:0]  end_off;                   // Ending byte offset
  reg        partial_or_powerfail_flag; // Staging contents not valid
  reg        copy_done_flag;            // Staging already committed
  reg        first_byte;                // Next data byte is the first
  reg [15:0] crc;                       // Running checksum
  reg [2:0]  rd_idx;                    // Readback byte index
  reg [1:0]  pat_idx;                   // Commit pattern byte index
  reg        pat_ok;                    // Commit pattern matched so far
  reg [7:0]  scratch [0:ROW_BYTES-1];   // Staging buffer, flip-flops

  wire [7:0] end_offset_status;         // Status byte as read back
  reg        push_valid;                // Sequencer offers a byte
  reg  [7:0] push_data;                 // Byte offered
  wire       push_ready;                // Buffer took it
  wire       push_fire;                 // Byte handed over this cycle
  reg  [2:0] wr_idx;                    // Staging slot of incoming byte
  reg  [1:0] prot;                      // Protection of target byte
  reg  [7:0] stage_byte;                // Value that lands in staging
  wire       target_ok;                 // Row may be committed
  wire       copy_blocked;              // Copy protection applies
  wire [7:0] pat_expect;                // Commit byte expected now
  integer    i;                         // Reset loop index

  // ========================================================================
  // Functions
  // ========================================================================

  // One byte into the checksum, least significant bit first
  function [15:0] crc16_byte;
    input [15:0] c;
    input [7:0]  d;
    integer      b;
    reg   [15:0] r;
    begin
      r = c;
      for (b = 0; b < 8; b = b + 1) begin
        if (r[0] ^ d[b]) begin
          r = (r >> 1) ^ `CRC16_POLY_REFL;
        end else begin
          r = r >> 1;
        end
      end
      crc16_byte = r;
    end
  endfunction

  // True for either locking code
  function is_locked_code;
    input [7:0] v;
    begin
      is_locked_code = (v == `PROT_WRITE_LOCK) || (v == `PROT_AND_MODE);
    end
  endfunction

  // Protection of one target byte
  function [1:0] prot_mode;
    input [15:0] a;
    input [7:0]  pp;
    input [7:0]  cur;
    begin
      if (a[15:8] != 8'h00) begin
        prot_mode = P_OPEN;                          // see (R14)
      end else if (a[7:0] < `ADDR_REG_PAGE) begin
        // Data page: its own control byte decides, see (R21)
        if (pp == `PROT_WRITE_LOCK) begin
          prot_mode = P_LOCK;
        end else if (pp == `PROT_AND_MODE) begin
          prot_mode = P_AND;
        end else begin
          prot_mode = P_OPEN;
        end
      end else if (a[7:0] <= `ADDR_COPY_PROT) begin
        // Control bytes lock themselves once set, see (R19)
        prot_mode = is_locked_code(cur) ? P_LOCK : P_OPEN;
      end else if (a[7:0] == `ADDR_FACTORY) begin
        prot_mode = P_LOCK;                          // see (R19)
      end else begin
        prot_mode = P_OPEN;
      end
    end
  endfunction

  // ========================================================================
  // Status byte; unused bits held at zero
  // ========================================================================
  assign end_offset_status = {copy_done_flag, 1'b0,
                              partial_or_powerfail_flag,
                              2'b00, end_off};       // see (R04)

  // Row boundary inside data or register rows, see (R06)
  assign target_ok = (target_address_high == 8'h00) &&
                     (target_address_low < `ADDR_RESERVED_ROW) &&
                     (target_address_low[2:0] == 3'h0);

  // Register rows and write-locked pages are frozen by copy protection
  assign copy_blocked = is_locked_code(copy_prot) &&
                        ((target_address_low >= `ADDR_REG_PAGE) ||
                         (page_prot == `PROT_WRITE_LOCK));

  // Commit pattern: low, high, status, see (R10)
  assign pat_expect = (pat_idx == 2'h0) ? target_address_low :
                      (pat_idx == 2'h1) ? target_address_high :
                      end_offset_status;

  // ========================================================================
  // Outgoing byte select
  // ========================================================================
  always @* begin
    push_valid = 1'b1;
    case (state)
      S_R_AL:     push_data = target_address_low;   // see (R07)
      S_R_AH:     push_data = target_address_high;  // see (R07)
      S_R_ST:     push_data = end_offset_status;    // see (R07)
      S_R_DATA:   push_data = scratch[rd_idx];
      S_R_CRC_LO: push_data = ~crc[7:0];
      S_R_CRC_HI: push_data = ~crc[15:8];
      S_W_CRC_LO: push_data = ~crc[7:0];            // see (R16)
      S_W_CRC_HI: push_data = ~crc[15:8];           // see (R16)
      default: begin
        push_valid = 1'b0;
        push_data  = 8'h00;
      end
    endcase
  end

  assign push_fire = push_valid && push_ready;

  // ========================================================================
  // Incoming data byte placement and protection
  // ========================================================================
  always @* begin
    wr_idx = first_byte ? target_address_low[2:0]
                        : end_off + 3'h1;            // see (R13)
    prot   = prot_mode(mem_addr, page_prot, mem_rdata);
    case (prot)
      P_LOCK:  stage_byte = mem_rdata;               // see (R17)
      P_AND:   stage_byte = rx_data & mem_rdata;     // see (R18)
      default: stage_byte = rx_data;
    endcase
  end

  // ========================================================================
  // Speed select, standard after reset
  // ========================================================================
  always @(posedge clock) begin
    if (rst) begin
      fast_speed_select <= `RST_FAST_SPEED;          // see (R11)
    end else if (speed_fast_req) begin
      fast_speed_select <= 1'b1;                     // see (R11)
    end else if (speed_std_req) begin
      fast_speed_select <= 1'b0;
    end
  end

  // ========================================================================
  // Staging byte picked by the array during a commit
  // ========================================================================
  always @(posedge clock) begin
    if (rst) begin
      scratch_out <= 8'h00;
    end else begin
      scratch_out <= scratch[scratch_sel];
    end
  end

  // ========================================================================
  // Command sequencer
  // ========================================================================
  always @(posedge clock) begin
    if (rst) begin
      // Reset stands for power loss: contents become invalid
      state                     <= S_IDLE;
      target_address_low        <= 8'h00;
      target_address_high       <= 8'h00;
      end_off                   <= 3'h0;
      partial_or_powerfail_flag <= `RST_PARTIAL;     // see (R02)
      copy_done_flag            <= `RST_COPY_DONE;
      first_byte                <= 1'b0;
      crc                       <= `RST_CRC;
      rd_idx                    <= 3'h0;
      pat_idx                   <= 2'h0;
      pat_ok                    <= 1'b0;
      mem_addr                  <= 16'h0000;
      copy_start                <= 1'b0;
      for (i = 0; i < ROW_BYTES; i = i + 1) begin
        scratch[i] <= 8'h00;
      end
    end else begin
      copy_start <= 1'b0;
      if (frame_end) begin
        // Master may stop anywhere; offset stays at last full byte
        state <= S_IDLE;                             // see (R20)
      end else begin
        case (state)
          S_IDLE: begin
            if (frame_start) begin
              state <= S_CMD;
            end
          end
          S_CMD: begin
            if (rx_valid) begin
              crc     <= crc16_byte(`RST_CRC, rx_data); // see (R15)
              pat_idx <= 2'h0;
              pat_ok  <= 1'b1;
              rd_idx  <= target_address_low[2:0];
              case (rx_data)
                `CMD_STAGE_WRITE:    state <= S_W_AL;
                `CMD_STAGE_READBACK: state <= S_R_AL;
                `CMD_STAGE_COMMIT:   state <= S_C_PAT;
                default:             state <= S_HOLD;
              endcase
            end
          end
          S_W_AL: begin
            if (rx_valid) begin
              target_address_low <= rx_data;
              crc   <= crc16_byte(crc, rx_data);     // see (R15)
              state <= S_W_AH;
            end
          end
          S_W_AH: begin
            if (rx_valid) begin
              // Any address is taken; commit sorts out validity
              target_address_high <= rx_data;        // see (R14)
              mem_addr   <= {rx_data, target_address_low};
              end_off    <= target_address_low[2:0]; // see (R01)
              partial_or_powerfail_flag <= 1'b1;     // see (R02)
              first_byte <= 1'b1;
              crc   <= crc16_byte(crc, rx_data);     // see (R15)
              state <= S_W_DATA;
            end
          end
          S_W_DATA: begin
            if (rx_valid) begin
              scratch[wr_idx] <= stage_byte;         // see (R13)
              end_off         <= wr_idx;             // see (R01)
              first_byte      <= 1'b0;
              copy_done_flag  <= 1'b0;               // see (R05)
              // Checksum sees the byte as sent, not as stored
              crc <= crc16_byte(crc, rx_data);       // see (R15)
              // Look ahead so the array settles before next byte
              mem_addr <= {target_address_high,
                           target_address_low[7:3], wr_idx + 3'h1};
              if (wr_idx == `ST_END_LAST) begin
                partial_or_powerfail_flag <= 1'b0;   // see (R02)
                state <= S_W_CRC_LO;                 // see (R16)
              end
            end
          end
          S_W_CRC_LO: begin
            if (push_fire) begin
              state <= S_W_CRC_HI;
            end
          end
          S_W_CRC_HI: begin
            if (push_fire) begin
              state <= S_HOLD;
            end
          end
          S_R_AL, S_R_AH, S_R_ST: begin
            if (push_fire) begin
              crc   <= crc16_byte(crc, push_data);
              state <= state + 4'h1;
            end
          end
          S_R_DATA: begin
            if (push_fire) begin
              crc    <= crc16_byte(crc, push_data);
              rd_idx <= rd_idx + 3'h1;
              if (rd_idx == end_off) begin
                state <= S_R_CRC_LO;
              end
            end
          end
          S_R_CRC_LO: begin
            if (push_fire) begin
              state <= S_R_CRC_HI;
            end
          end
          S_R_CRC_HI: begin
            if (push_fire) begin
              state <= S_HOLD;
            end
          end
          S_C_PAT: begin
            if (rx_valid) begin
              pat_idx <= pat_idx + 2'h1;
              if (pat_idx == 2'h2) begin
                state <= S_HOLD;
                // Flag and copy only if every gate passes
                if (pat_ok && (rx_data == pat_expect) && target_ok &&
                    !partial_or_powerfail_flag && !copy_blocked) begin
                  copy_done_flag <= 1'b1;            // see (R22)
                  copy_start     <= 1'b1;            // see (R22)
                  mem_addr <= {target_address_high, target_address_low};
                end
              end else if (rx_data != pat_expect) begin
                pat_ok <= 1'b0;                      // see (R10)
              end
            end
          end
          S_HOLD: begin
            // Ignore everything until the master ends the frame
            state <= S_HOLD;
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ========================================================================
  // Outgoing byte buffer; a stalled link stalls the sequencer
  // ========================================================================
  two_entry_buffer #(
    .WIDTH (8)
  ) u_tx_buffer (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

endmodule // staging_write_path

`default_nettype wire

//--- hdl/staging_consts.vh
`ifndef STAGING_CONSTS_VH
`define STAGING_CONSTS_VH

// ==========================================================================
// Memory function command codes
// ==========================================================================
`define CMD_STAGE_WRITE    8'h0f
`define CMD_STAGE_READBACK 8'haa
`define CMD_STAGE_COMMIT   8'h55

// ==========================================================================
// Protection byte codes
// ==========================================================================
`define PROT_WRITE_LOCK    8'h55
`define PROT_AND_MODE      8'haa

// ==========================================================================
// Address map limits
// ==========================================================================
`define ADDR_REG_PAGE      8'h80
`define ADDR_COPY_PROT     8'h84
`define ADDR_FACTORY       8'h85
`define ADDR_RESERVED_ROW  8'h88

// ==========================================================================
// End offset and status field positions
// ==========================================================================
`define ST_COPY_DONE_BIT   7
`define ST_PARTIAL_BIT     5
`define ST_END_MSB         2
`define ST_END_LAST        3'h7

// ==========================================================================
// Reset values
// ==========================================================================
`define RST_PARTIAL        1'b1
`define RST_COPY_DONE      1'b0
`define RST_FAST_SPEED     1'b0
`define RST_CRC            16'h0000

// ==========================================================================
// Checksum polynomial, reflected form
// ==========================================================================
`define CRC16_POLY_REFL    16'ha001

`endif

//--- hdl/two_entry_buffer.v
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Two-entry buffer: output stage plus one skid entry
// ==========================================================================
module two_entry_buffer #(
  parameter WIDTH = 8
) (
  input  wire             clock,     // System clock
  input  wire             rst,       // Synchronous reset, active high
  input  wire             in_valid,  // Producer offers a word
  output wire             in_ready,  // Buffer can take a word
  input  wire [WIDTH-1:0] in_data,   // Word from producer
  output reg              out_valid, // Head word present
  input  wire             out_ready, // Consumer takes head word
  output reg  [WIDTH-1:0] out_data   // Head word
);

  reg             skid_valid;        // Second entry occupied
  reg [WIDTH-1:0] skid_data;         // Second entry contents

  // Ready only looks at a flop, so no path runs consumer to producer
  assign in_ready = ~skid_valid;

  // Advance head when empty or drained, otherwise park in the skid entry
  always @(posedge clock) begin
    if (rst) begin
      out_valid  <= 1'b0;
      out_data   <= {WIDTH{1'b0}};
      skid_valid <= 1'b0;
      skid_data  <= {WIDTH{1'b0}};
    end else if (out_ready || !out_valid) begin
      if (skid_valid) begin
        // Older word first
        out_data   <= skid_data;
        out_valid  <= 1'b1;
        skid_valid <= 1'b0;
      end else begin
        // Pass through
        out_valid <= in_valid;
        if (in_valid) begin
          out_data <= in_data;
        end
      end
    end else if (in_valid && !skid_valid) begin
      // Consumer stalled: keep the word instead of losing it
      skid_valid <= 1'b1;
      skid_data  <= in_data;
    end
  end

endmodule // two_entry_buffer

`default_nettype wire

//--- dv/staging_write_path_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Port checks on the staging write path
module staging_write_path_assertions (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        speed_fast_req,
  input wire logic        speed_std_req,
  input wire logic        fast_speed_select,
  input wire logic        rx_valid,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [7:0]  tx_data,
  input wire logic [15:0] mem_addr,
  input wire logic        copy_start
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Byte offered but not yet taken by the link
  sequence held_s; tx_valid && !tx_ready; endsequence
  // Commit strobe lasts exactly one cycle
  sequence pulse_s; copy_start ##1 !copy_start; endsequence
  chk_tx_stands: assert property (held_s |=> tx_valid &&
    $stable(tx_data)) else $error("tx byte changed before taken");
  chk_fast_set: assert property (speed_fast_req |=>
    fast_speed_select) else $error("fast speed not selected");
  chk_std_clear: assert property (speed_std_req && !speed_fast_req
    |=> !fast_speed_select) else $error("standard speed not restored");
  chk_speed_keep: assert property (!speed_fast_req && !speed_std_req
    |=> $stable(fast_speed_select)) else $error("speed changed unasked");
  chk_reset_std: assert property ($fell(rst) |-> !fast_speed_select
    && !tx_valid) else $error("not standard after reset");
  chk_copy_pulse: assert property (copy_start |-> pulse_s)
    else $error("commit strobe too long");
  chk_copy_row: assert property (copy_start |-> mem_addr[2:0]
    == 3'h0 && mem_addr < 16'h0088) else $error("commit of misaligned row");
  chk_copy_cause: assert property (copy_start |-> $past(rx_valid)
    || $past(rx_valid, 2)) else $error("commit without pattern byte");
endmodule // staging_write_path_assertions
bind staging_write_path staging_write_path_assertions chk (.clock, .rst,
  .speed_fast_req, .speed_std_req, .fast_speed_select, .rx_valid,
  .tx_valid, .tx_ready, .tx_data, .mem_addr, .copy_start);
`default_nettype wire

//--- dv/array_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Memory array beside the staging path, with row commit
module array_model (
  input  wire logic        clock,
  input  wire logic [15:0] mem_addr,
  input  wire logic        copy_start,
  input  wire logic [7:0]  scratch_out,
  output logic      [7:0]  mem_rdata,
  output logic      [7:0]  page_prot,
  output logic      [7:0]  copy_prot,
  output logic      [2:0]  scratch_sel
);
  logic [7:0]  mem [0:143]; // Array bytes, written by bench too
  logic [15:0] base;        // Row being committed
  logic [3:0]  n = 4'h0;    // Commit step, zero when idle
  // Unmapped space reads as ones, never as a stale byte
  assign mem_rdata   = (mem_addr < 16'h0090) ? mem[mem_addr[7:0]] : 8'hff;
  assign page_prot   = (mem_addr < 16'h0080) ? mem[{6'h20, mem_addr[6:5]}]
                                             : 8'h00;
  assign copy_prot   = mem[8'h84];
  assign scratch_sel = n[2:0] - 3'h1;
  // Staging byte arrives one cycle after its index
  always @(posedge clock) begin
    if (copy_start) begin
      base <= mem_addr;
      n    <= 4'h1;
    end else if (n != 4'h0) begin
      if (n > 4'h1) mem[base[7:0] + n - 2] <= scratch_out;
      n <= (n == 4'h9) ? 4'h0 : n + 4'h1;
    end
  end
endmodule // array_model
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Bench: link master and reference model
module testbench;
  logic        clock = 0, rst = 1, speed_fast_req = 0, speed_std_req = 0;
  logic        frame_start = 0, frame_end = 0, rx_valid = 0, tx_ready = 0;
  logic [7:0]  rx_data = 0, al, ah, sb, b, stage [0:7];
  logic        fast_speed_select, tx_valid, copy_start, seen_copy;
  logic [7:0]  tx_data, mem_rdata, page_prot, copy_prot, scratch_out;
  logic [15:0] mem_addr, seen_addr, crc;
  logic [2:0]  scratch_sel;
  int          failures = 0, total_checks = 0, cycles = 0;
  staging_write_path dut (.clock, .rst, .speed_fast_req, .speed_std_req,
    .fast_speed_select, .frame_start, .frame_end, .rx_valid, .rx_data,
    .tx_valid, .tx_ready, .tx_data, .mem_addr, .mem_rdata, .page_prot,
    .copy_prot, .copy_start, .scratch_sel, .scratch_out);
  array_model arr (.clock, .mem_addr, .copy_start, .scratch_out,
    .mem_rdata, .page_prot, .copy_prot, .scratch_sel);
  always #5 clock = ~clock;
  // ========
  // Hang guard and commit monitor
  always @(posedge clock) begin
    cycles++;
    if (copy_start === 1'b1) begin seen_copy <= 1; seen_addr <= mem_addr; end
    if (cycles == 20000) begin failures++; wrap_up(); end
  end
  task check(input string n, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Reflected checksum step, least significant bit first
  function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] d);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ d[i]) ? (c >> 1) ^ 16'ha001 : c >> 1;
    return c;
  endfunction
  // Released data line shows the inverse of the last byte
  task put(input logic [7:0] v);
    @(negedge clock); rx_valid = 1; rx_data = v; crc = crc_step(crc, v);
    @(negedge clock); rx_valid = 0; rx_data = ~v;
  endtask
  task start(input logic [7:0] cmd);
    @(negedge clock); frame_start = 1; crc = 0;
    @(negedge clock); frame_start = 0; put(cmd);
  endtask
  task stop; @(negedge clock); frame_end = 1;
    @(negedge clock); frame_end = 0; endtask
  // Link takes a byte, stalling at random
  task get(input string n, input logic [7:0] exp);
    logic r;
    for (int i = 0; i < 80; i++) begin
      @(negedge clock);
      r = tx_valid === 1'b1 && $urandom_range(2) != 0;
      tx_ready = r;
      if (r) begin
        check(n, tx_data, exp); crc = crc_step(crc, tx_data);
        @(negedge clock); tx_ready = 0; return;
      end
    end
    check(n, 16'h0100, exp);
  endtask
  task readback(input int t, e);
    logic [15:0] x;
    start(8'haa); get("addr lo", al); get("addr hi", ah);
    get("status", sb);
    for (int k = t; k <= e; k++) get("stage", stage[k]);
    x = ~crc; get("rb crc lo", x[7:0]); get("rb crc hi", x[15:8]);
    stop;
  endtask
  task run(input logic [15:0] a, input logic [7:0] prot, input int cnt, go);
    int t, e; logic [15:0] x; logic [7:0] m;
    arr.mem[8'h80 + a[6:5]] = prot;
    al = a[7:0]; ah = a[15:8]; t = a[2:0]; e = t + cnt - 1;
    start(8'h0f); put(al); put(ah);
    for (int k = t; k <= e; k++) begin
      b = $urandom; m = arr.mem[(a & 16'hfff8) + k];
      stage[k] = prot == 8'h55 ? m : prot == 8'haa ? b & m : b;
      put(b);
    end
    sb = {1'b0, 1'b0, e != 7, 2'b00, e[2:0]};
    x = ~crc;
    if (e == 7) begin
      get("crc lo", x[7:0]); get("crc hi", x[15:8]);
    end
    stop; readback(t, e);
    if (go) begin
      seen_copy = 0;
      start(8'h55); put(al); put(ah); put(sb);
      repeat (20) @(negedge clock);
      check("copy go", seen_copy, a[2:0] == 0 && e == 7);
      stop;
      if (seen_copy) begin
        check("copy addr", seen_addr, a); sb[7] = 1;
        for (int k = 0; k < 8; k++)
          check("array", arr.mem[a + k], stage[k]);
        readback(t, e);
      end
    end
    $display("test at %h done", a);
  endtask
  // ========
  // Main sequence
  initial begin
    void'($urandom(32'h06968527));
    for (int i = 0; i < 144; i++) arr.mem[i] = $urandom;
    arr.mem[8'h84] = 8'h00;
    repeat (16) @(posedge clock);
    @(negedge clock); rst = 0;
    check("speed", fast_speed_select, 0);
    for (int k = 1; k < 4; k++) begin
      @(negedge clock); speed_fast_req = k[0]; speed_std_req = k[1];
      @(negedge clock); speed_fast_req = 0; speed_std_req = 0;
      check("speed", fast_speed_select, k != 2);
    end
    $display("test speed done");
    run(16'h0000, 8'h00, 8, 1);
    run(16'h0020, 8'haa, 8, 0);
    run(16'h0043, 8'h55, 2, 1);
    run(16'h0040, 8'h55, 8, 1);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
